// ---- design/lsdp_pkg.sv ----
// load-store data port: shared types and constants
// What this block does
// - loads and stores of 32-bit words, 16-bit halfwords and 8-bit bytes
// - request stays high until grant is seen high for one cycle
// - write enable high for stores, low for loads, alongside the request
// - byte enables mark each byte lane accessed, alongside the request
// - store data driven on the write word alongside the request
// - load data captured in the cycle response valid is high
// - address-phase outputs may change the cycle after a grant
// - never more than two granted transactions awaiting response
// - no address-misaligned exception is ever raised
// - unaligned word and word-crossing halfword split into two transactions
// - the lower-address half of a split access goes out first
// - accesses within one word use a single transaction
// - optional user, id, ready and error signals omitted, tied to defaults
// - post-increment exists only when the extension parameter equals 1
// - post-increment accesses base address; base register gets base plus offset
package lsdp_pkg;

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam bit        LSDP_EXT_DEFAULT = 1'h1;
  localparam logic [1:0] LSDP_MAX_OUT    = 2'h2;
  localparam logic [31:0] LSDP_WORD_STEP = 32'h4;
  localparam logic [1:0] LSDP_ALIGN_MASK = 2'h0;
  localparam logic [3:0] LSDP_BE_BYTE    = 4'h1;
  localparam logic [3:0] LSDP_BE_HALF    = 4'h3;
  localparam logic [3:0] LSDP_BE_WORD    = 4'hF;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSDP_SZ_BYTE = 2'h0,
    LSDP_SZ_HALF = 2'h1,
    LSDP_SZ_WORD = 2'h2
  } lsdp_size_t;

  typedef enum logic [2:0] {
    LSDP_ST_IDLE  = 3'h1,
    LSDP_ST_REQ   = 3'h2,
    LSDP_ST_WAIT2 = 3'h4
  } lsdp_fsm_t;

  typedef struct packed {
    logic        we;
    lsdp_size_t  size;
    logic        sign_ext;
    logic        post_inc;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] offset;
  } lsdp_cmd_t;

  typedef struct packed {
    logic        first;
    logic        second;
    logic        we;
    lsdp_size_t  size;
    logic        sign_ext;
    logic [1:0]  off;
  } lsdp_entry_t;

  typedef struct packed {
    lsdp_fsm_t        fsm;
    logic             req;
    logic [31:0]      addr;
    logic             we;
    logic [3:0]       be;
    logic [31:0]      wdata;
    logic [3:0]       hi_be;
    logic [31:0]      hi_wdata;
    lsdp_entry_t      cur;
    logic [1:0]       cnt;
    lsdp_entry_t [1:0] q;
    logic [31:0]      hold;
    logic             cmd_ready;
    logic             rsp_valid;
    logic [31:0]      rsp_rdata;
    logic             base_valid;
    logic [31:0]      base_value;
  } lsdp_state_t;

endpackage

// ---- design/lsdp_port.sv ----
// load-store data port: request/grant address phase, in-order response phase
`timescale 1ns/1ns
module lsdp_port
  import lsdp_pkg::*;
#(
  parameter bit custom_extensions_param = LSDP_EXT_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire lsdp_cmd_t   cmd,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             base_update_valid,
  output logic [31:0]      base_update_value,
  output logic             lsu_request_out,
  output logic [31:0]      lsu_address_out,
  output logic             lsu_write_enable_out,
  output logic [3:0]       lsu_byte_enables_out,
  output logic [31:0]      lsu_write_word_out,
  input  wire logic        lsu_grant_in,
  input  wire logic        lsu_response_valid_in,
  input  wire logic [31:0] lsu_read_word_in
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] size_mask(input lsdp_size_t sz);
    logic [3:0] m;
    m = LSDP_BE_BYTE;
    case (sz)
      LSDP_SZ_HALF: m = LSDP_BE_HALF;
      LSDP_SZ_WORD: m = LSDP_BE_WORD;
      default:      m = LSDP_BE_BYTE;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] extend(input logic [31:0] v, input lsdp_size_t sz, input logic sx);
    logic [31:0] r;
    r = v;
    case (sz)
      LSDP_SZ_BYTE: r = {{24{sx & v[7]}}, v[7:0]};
      LSDP_SZ_HALF: r = {{16{sx & v[15]}}, v[15:0]};
      default:      r = v;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  lsdp_state_t       s_reg;
  lsdp_state_t       s_next;
  logic              granted;
  logic              pop;
  logic              accept;
  lsdp_entry_t       head;
  lsdp_entry_t [1:0] q_tmp;
  logic [1:0]        cnt_tmp;
  logic [7:0]        be8;
  logic [63:0]       wd64;
  logic [31:0]       merged;

  // no exception output exists: misaligned accesses are always carried out
  // optional user, id, ready and error signals are absent

  always_comb begin
    s_next            = s_reg;
    s_next.rsp_valid  = 1'b0;
    s_next.base_valid = 1'b0;
    granted           = s_reg.req && lsu_grant_in; // early grant ignored without request
    pop               = lsu_response_valid_in && (s_reg.cnt != 2'h0);
    accept            = cmd_valid && s_reg.cmd_ready;
    head              = s_reg.q[0];
    be8               = {4'h0, size_mask(cmd.size)} << cmd.addr[1:0];
    wd64              = {32'h0, cmd.wdata} << {cmd.addr[1:0], 3'h0};

    // response phase, strictly in issue order
    if (head.second) begin
      merged = s_reg.hold | (lsu_read_word_in << {2'h0 - head.off, 3'h0});
    end else begin
      merged = lsu_read_word_in >> {head.off, 3'h0};
    end
    if (pop) begin
      if (head.first) begin
        s_next.hold = merged;
      end else begin
        s_next.rsp_valid = 1'b1;
        s_next.rsp_rdata = head.we ? 32'h0 : extend(merged, head.size, head.sign_ext);
      end
    end

    // ---------------- outstanding tracking
    q_tmp   = s_reg.q;
    cnt_tmp = s_reg.cnt;
    if (pop) begin
      q_tmp[0] = q_tmp[1];
      cnt_tmp  = cnt_tmp - 2'h1;
    end
    if (granted) begin
      q_tmp[cnt_tmp[0]] = s_reg.cur; // response comes a cycle later at earliest
      cnt_tmp           = cnt_tmp + 2'h1;
    end
    s_next.q   = q_tmp;
    s_next.cnt = cnt_tmp;

    // ---------------- address phase
    case (s_reg.fsm)
      LSDP_ST_IDLE: begin
        if (accept) begin
          s_next.req          = 1'b1;
          s_next.fsm          = LSDP_ST_REQ;
          s_next.addr         = {cmd.addr[31:2], LSDP_ALIGN_MASK};
          s_next.we           = cmd.we;
          s_next.be           = be8[3:0];
          s_next.wdata        = wd64[31:0];
          s_next.hi_be        = be8[7:4];
          s_next.hi_wdata     = wd64[63:32];
          s_next.cur.first    = |be8[7:4];
          s_next.cur.second   = 1'b0;
          s_next.cur.we       = cmd.we;
          s_next.cur.size     = cmd.size;
          s_next.cur.sign_ext = cmd.sign_ext;
          s_next.cur.off      = cmd.addr[1:0];
          if (cmd.post_inc && custom_extensions_param) begin
            s_next.base_valid = 1'b1;
            s_next.base_value = cmd.addr + cmd.offset; // memory sees the base
          end
        end
      end
      LSDP_ST_REQ: begin
        if (granted) begin // held until granted
          if (s_reg.cur.first) begin
            // upper word follows the lower one
            s_next.addr       = s_reg.addr + LSDP_WORD_STEP;
            s_next.be         = s_reg.hi_be;
            s_next.wdata      = s_reg.hi_wdata;
            s_next.cur.first  = 1'b0;
            s_next.cur.second = 1'b1;
            if (cnt_tmp == LSDP_MAX_OUT) begin
              s_next.req = 1'b0;
              s_next.fsm = LSDP_ST_WAIT2;
            end
          end else begin
            s_next.req = 1'b0;
            s_next.fsm = LSDP_ST_IDLE;
          end
        end
      end
      LSDP_ST_WAIT2: begin
        if (cnt_tmp != LSDP_MAX_OUT) begin
          s_next.req = 1'b1;
          s_next.fsm = LSDP_ST_REQ;
        end
      end
      default: begin
        s_next.req = 1'b0;
        s_next.fsm = LSDP_ST_IDLE;
      end
    endcase
    s_next.cmd_ready = (s_next.fsm == LSDP_ST_IDLE) && (cnt_tmp != LSDP_MAX_OUT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg     <= '0;
      s_reg.fsm <= LSDP_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_ready            = s_reg.cmd_ready;
  assign rsp_valid            = s_reg.rsp_valid;
  assign rsp_rdata            = s_reg.rsp_rdata;
  assign base_update_valid    = s_reg.base_valid;
  assign base_update_value    = s_reg.base_value;
  assign lsu_request_out      = s_reg.req;
  assign lsu_address_out      = s_reg.addr;
  assign lsu_write_enable_out = s_reg.we;
  assign lsu_byte_enables_out = s_reg.be;
  assign lsu_write_word_out   = s_reg.wdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  req_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_request_out && !lsu_grant_in |=> lsu_request_out)
    else $error("request dropped before grant");

  phase_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_request_out && !lsu_grant_in |=> $stable(lsu_address_out) && $stable(lsu_byte_enables_out)
      && $stable(lsu_write_enable_out) && $stable(lsu_write_word_out))
    else $error("address phase changed before grant");

  outstanding_max_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.cnt <= LSDP_MAX_OUT && !(s_reg.cnt == LSDP_MAX_OUT && lsu_request_out))
    else $error("too many outstanding transactions");

  split_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_request_out && lsu_grant_in && s_reg.cur.first
      |=> lsu_address_out == $past(lsu_address_out) + LSDP_WORD_STEP)
    else $error("split upper half not at next word");

  word_aligned_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_request_out |-> lsu_address_out[1:0] == 2'h0 && lsu_byte_enables_out != 4'h0)
    else $error("bad address or empty byte enables");

  single_txn_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && (cmd.size == LSDP_SZ_BYTE || cmd.addr[1:0] == 2'h0
      || (cmd.size == LSDP_SZ_HALF && cmd.addr[1:0] != 2'h3))
      |=> lsu_request_out && !s_reg.cur.first)
    else $error("non-crossing access was split");

  word_split_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && ((cmd.size == LSDP_SZ_WORD && cmd.addr[1:0] != 2'h0)
      || (cmd.size == LSDP_SZ_HALF && cmd.addr[1:0] == 2'h3)) |=> lsu_request_out && s_reg.cur.first)
    else $error("misaligned access not split");

  split_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_request_out && lsu_grant_in && s_reg.cur.first
      |=> s_reg.cur.second && (lsu_request_out || s_reg.fsm == LSDP_ST_WAIT2))
    else $error("split upper half not issued");

  store_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_response_valid_in && s_reg.cnt != 2'h0 && !head.first && head.we
      |=> rsp_valid && rsp_rdata == 32'h0)
    else $error("store completion wrong");

  load_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    lsu_response_valid_in && s_reg.cnt != 2'h0 && !head.first && !head.second && !head.we
      && head.size == LSDP_SZ_WORD |=> rsp_valid && rsp_rdata == $past(lsu_read_word_in))
    else $error("load data not captured");

  post_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && cmd.post_inc && custom_extensions_param
      |=> base_update_valid && base_update_value == $past(cmd.addr) + $past(cmd.offset)
        && lsu_address_out[31:2] == $past(cmd.addr[31:2]))
    else $error("post increment wrong");

endmodule

// ---- verif/lsdp_mem_model.sv ----
// data memory model answering the port in order, prompt or slow
`timescale 1ns/1ns
module lsdp_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        stall,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic        we,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  output logic             gnt,
  output logic             rvalid,
  output logic [31:0]      rdata
);
  logic [31:0] mem [16];
  logic [31:0] q   [$];
  int          dly;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gnt    <= 1'h0;
      rvalid <= 1'h0;
      rdata  <= 32'h0;
      dly    <= 0;
      q.delete();
      foreach (mem[i]) mem[i] = 32'h0;
    end else begin
      // grant ahead of any request when prompt, every other cycle when slow
      gnt    <= slow ? !gnt : 1'h1;
      rvalid <= 1'h0;
      rdata  <= ~rdata;
      if (req && gnt) begin
        for (int i = 0; i < 4; i++)
          if (we && be[i]) mem[addr[5:2]][8*i+:8] = wdata[8*i+:8];
        // stores answer with junk data; one answer queued per grant
        q.push_back(we ? 32'hA5A5A5A5 : mem[addr[5:2]]);
      end
      // queued at the grant edge, so never answered in the grant cycle
      if (dly > 0) begin
        dly <= dly - 1;
      end else if (q.size() != 0 && !stall) begin
        // holding answers back lets the port fill both outstanding slots
        rvalid <= 1'h1;
        rdata  <= q.pop_front();
        dly    <= slow ? 3 : 0;
      end
    end
  end
endmodule

// ---- verif/load_store_data_port_test.sv ----
// self-checking bench for the load-store data port
`timescale 1ns/1ns
module load_store_data_port_test;
  import lsdp_pkg::*;
  typedef struct {
    logic [2:0] f;
    lsdp_size_t sz;
    logic [31:0] a, wd, exp;
    int ntx;
    logic [3:0] be0;
  } lsdp_row_t;
  localparam lsdp_size_t SB = LSDP_SZ_BYTE, SH = LSDP_SZ_HALF, SW = LSDP_SZ_WORD;
  // f = {store, sign extend, post increment}
  lsdp_row_t rows [17] = '{
    '{3'h4, SW, 32'h0, 32'h11223344, 32'h0, 1, 4'hF}, '{3'h4, SW, 32'h5, 32'hA1B2C3D4, 32'h0, 2, 4'hE},
    '{3'h4, SH, 32'hB, 32'hBEEF, 32'h0, 2, 4'h8}, '{3'h4, SB, 32'h2, 32'h7F, 32'h0, 1, 4'h4},
    '{3'h0, SW, 32'h0, 32'h0, 32'h117F3344, 1, 4'hF}, '{3'h0, SW, 32'h5, 32'h0, 32'hA1B2C3D4, 2, 4'hE},
    '{3'h2, SH, 32'hB, 32'h0, 32'hFFFFBEEF, 2, 4'h8}, '{3'h0, SH, 32'hB, 32'h0, 32'h0000BEEF, 2, 4'h8},
    '{3'h1, SH, 32'h6, 32'h0, 32'h0000B2C3, 1, 4'hC}, '{3'h2, SB, 32'h2, 32'h0, 32'h0000007F, 1, 4'h4},
    '{3'h2, SB, 32'h7, 32'h0, 32'hFFFFFFB2, 1, 4'h8}, '{3'h0, SB, 32'h8, 32'h0, 32'h000000A1, 1, 4'h1},
    '{3'h0, SW, 32'h7, 32'h0, 32'h0000A1B2, 2, 4'h8}, '{3'h0, SW, 32'h6, 32'h0, 32'h00A1B2C3, 2, 4'hC},
    '{3'h0, SH, 32'h3, 32'h0, 32'h00000011, 2, 4'h8}, '{3'h5, SB, 32'h20, 32'h5A, 32'h0, 1, 4'h1},
    '{3'h0, SB, 32'h20, 32'h0, 32'h0000005A, 1, 4'h1}};

  logic        clk, rst_n, cmd_valid, slow, stall, cmd_ready, rsp_valid, base_update_valid, req, we, gnt, rvalid;
  lsdp_cmd_t   cmd;
  logic [31:0] rsp_rdata, base_update_value, addr, wdata, rdata, base_seen;
  logic [3:0]  be;
  logic [36:0] gq [$];
  int          n_mismatch, compares;

  lsdp_port i_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .base_update_valid(base_update_valid),
    .base_update_value(base_update_value), .lsu_request_out(req), .lsu_address_out(addr),
    .lsu_write_enable_out(we), .lsu_byte_enables_out(be), .lsu_write_word_out(wdata),
    .lsu_grant_in(gnt), .lsu_response_valid_in(rvalid), .lsu_read_word_in(rdata));
  lsdp_mem_model i_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .stall(stall), .req(req), .addr(addr), .we(we), .be(be),
    .wdata(wdata), .gnt(gnt), .rvalid(rvalid), .rdata(rdata));

  // ----------------------------------------
  // monitor of granted transfers
  // ----------------------------------------
  always @(posedge clk) begin
    if (req && gnt) gq.push_back({we, be, addr});
    if (base_update_valid) base_seen <= base_update_value;
  end

  task automatic check(string name, logic [36:0] seen, logic [36:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic issue(lsdp_row_t r);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd       <= '{r.f[2], r.sz, r.f[1], r.f[0], r.a, r.wd, 32'h10};
    @(posedge clk iff cmd_ready);
    cmd_valid <= 1'h0;
  endtask

  task automatic wait_rsp;
    int i;
    for (i = 0; i < 300 && !rsp_valid; i++) @(posedge clk);
    if (i == 300) n_mismatch++;
  endtask

  task automatic run(lsdp_row_t r);
    gq.delete();
    issue(r);
    wait_rsp;
    check("result", 37'(rsp_rdata), 37'(r.exp));
    check("transfer count", 37'(gq.size()), 37'(r.ntx));
    check("first transfer", gq[0], {r.f[2], r.be0, r.a[31:2], 2'h0});
    if (r.ntx == 2) check("second address", 37'(gq[1][31:0]), 37'({r.a[31:2], 2'h0} + 32'h4));
    if (r.f[0]) check("base update", 37'(base_seen), 37'(r.a + 32'h10));
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    #400000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    rst_n = 1'h0;
    cmd_valid = 1'h0;
    slow = 1'h0;
    stall = 1'h0;
    cmd = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (rows[k]) run(rows[k]);
    $display("prompt memory rows done");
    slow <= 1'h1;
    foreach (rows[k]) run(rows[k]);
    $display("slow memory rows done");
    slow  <= 1'h0;
    stall <= 1'h1;
    gq.delete();
    issue(rows[4]);
    issue(rows[5]);
    repeat (3) @(posedge clk);
    check("parked request", 37'({req, cmd_ready}), 37'h0);
    check("parked transfers", 37'(gq.size()), 37'h2);
    stall <= 1'h0;
    wait_rsp;
    check("older result", 37'(rsp_rdata), 37'(rows[4].exp));
    @(posedge clk);
    wait_rsp;
    check("younger result", 37'(rsp_rdata), 37'(rows[5].exp));
    check("upper half", gq[2], {1'h0, 4'h1, 32'h8});
    $display("outstanding limit done");
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    check("outputs in reset", 37'({req, cmd_ready, rsp_valid}), 37'h0);
    rst_n <= 1'h1;
    @(posedge clk);
    run(rows[0]);
    run(rows[3]);
    run(rows[4]);
    $display("mid-run reset done");
    end_sim;
  end
endmodule
